// [bench/lbsd_card_model.sv]
`timescale 1ns/1ns
`default_nettype none

module lbsd_card_model (
	// Card bus from the host
	input wire logic sd_clk_in,
	input wire logic sd_cmd_in,
	input wire logic dat0_oe_in,
	input wire logic dat0_drv_in,
	// Resolved data wire
	output logic dat0_line_out,
	// Decoded traffic
	output logic [7:0] byte_out,
	output var int byte_count_out,
	output logic [5:0] cmd_idx_out,
	output var int cmd_count_out
);
	int cbit = 0;
	int dbit = 0;
	int busy = 0;
	int nbytes = 0;
	int ncmds = 0;
	logic [7:0] csh = 8'h00;
	logic [7:0] dsh = 8'h00;
	logic [7:0] last_byte = 8'h00;
	logic [5:0] last_idx = 6'h00;

	// Decoded traffic; one driver per output
	assign byte_out = last_byte;
	assign byte_count_out = nbytes;
	assign cmd_idx_out = last_idx;
	assign cmd_count_out = ncmds;

	// Pull-up wins when nobody drives; busy only once host lets go
	assign dat0_line_out = dat0_oe_in ? dat0_drv_in : (busy == 0);

	// Host changes lines on falls, so the card samples on rises
	always @(posedge sd_clk_in) begin
		if (busy > 0)
			busy = busy - 1;
		if (cbit == 0) begin
			if (!sd_cmd_in)
				cbit = 1;
		end else if (cbit < 8) begin
			csh = {csh[6:0], sd_cmd_in};
			cbit = cbit + 1;
		end else begin
			last_idx = csh[5:0];
			ncmds = ncmds + 1;
			cbit = 0;
		end
		if (dbit == 0) begin
			if (dat0_oe_in && !dat0_drv_in)
				dbit = 1;
		end else if (dbit < 9) begin
			dsh = {dsh[6:0], dat0_drv_in};
			dbit = dbit + 1;
		end else begin
			last_byte = dsh;
			nbytes = nbytes + 1;
			busy = 4;
			dbit = 0;
		end
	end
endmodule

`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic btn = 1'b1;
	lbsd_pkg::lbsd_stream_type din = '0;
	logic rdy, sclk, scmd, dout, doe, log_on, led, line;
	logic [7:0] cbyte;
	logic [5:0] cidx;
	int ccnt, bcnt;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int exp_log = 0;
	int exp_mnt = 0;
	int seed = 32'h77d64650;
	logic [7:0] q[$];
	realtime last = 0;
	logic ce = 1'b1;
	logic [6:0] snap;
	int seen = 0;

	lbsd_control #(.DEBOUNCE_CYC(4), .PRESS_MIN_CYC(20),
		.PRESS_LONG_CYC(60)) i_lbsd_control (.clk_in(clk_in),
		.rst_in(rst_in), .ce_in(ce), .log_push_button_in(btn),
		.log_data_in(din), .log_ready_out(rdy), .sd_clk_out(sclk),
		.sd_cmd_out(scmd), .sd_dat0_in(line), .sd_dat0_out(dout),
		.sd_dat0_oe_out(doe), .logging_on_out(log_on),
		.logging_status_led_out(led));
	lbsd_card_model i_lbsd_card_model (.sd_clk_in(sclk),
		.sd_cmd_in(scmd), .dat0_oe_in(doe), .dat0_drv_in(dout),
		.dat0_line_out(line), .byte_out(cbyte), .byte_count_out(bcnt),
		.cmd_idx_out(cidx), .cmd_count_out(ccnt));

	initial forever #5 clk_in = ~clk_in;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, well above the whole sequence
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// Card clock period, rise to rise
	always @(posedge sclk) begin
		if (last > 0)
			chk({7'h0, $realtime - last >= 30.3}, 8'h01);
		last = $realtime;
	end

	// Every byte the card sees must match the offered order; read settled
	always @(negedge clk_in) begin
		if (bcnt > seen) begin
			seen = bcnt;
			chk(cbyte, q.pop_front());
		end
	end

	task automatic state;
		chk({6'h0, log_on, led}, 8'(exp_log * 2 + exp_mnt));
	endtask

	// Bouncing contact on both edges; glitches shorter than the filter
	task automatic press(input int n);
		repeat (6) begin @(negedge clk_in); btn = ~btn; end
		@(negedge clk_in); btn = 1'b0;
		repeat (n) @(negedge clk_in);
		repeat (6) begin @(negedge clk_in); btn = ~btn; end
		@(negedge clk_in); btn = 1'b1;
		repeat (30) @(negedge clk_in);
		$display("press of %0d cycles done", n);
	endtask

	task automatic send(input logic [7:0] b);
		int t;
		@(negedge clk_in); din = {1'b1, b}; t = 0;
		while (rdy !== 1'b1 && t < 2000) begin @(negedge clk_in); t++; end
		if (t >= 2000)
			fail_count++;
		@(posedge clk_in); q.push_back(b);
		@(negedge clk_in); din.valid = 1'b0;
	endtask

	task automatic wait_cnt(ref int c, input int n);
		int t;
		t = 0;
		while (c < n && t < 3000) begin @(negedge clk_in); t++; end
		chk(8'(c), 8'(n));
	endtask

	initial begin
		repeat (16) @(negedge clk_in);
		chk({3'h0, rdy, scmd, doe, log_on, led}, 8'h18);
		rst_in = 1'b0;
		// Nothing may leave while off: two bytes fill the buffer
		send(8'($random(seed)));
		send(8'($random(seed)));
		@(negedge clk_in); chk({7'h0, rdy}, 8'h00);
		press(8); state();
		press(35); exp_log = 1; state();
		press(90); exp_mnt = 1; state();
		wait_cnt(ccnt, 1);
		chk({2'h0, cidx}, {2'h0, lbsd_pkg::CMD_MOUNT});
		repeat (4) send(8'($random(seed)));
		// Enable low must freeze the card bus and status mid-stream
		@(negedge clk_in);
		ce = 1'b0;
		snap = {sclk, scmd, doe, dout, rdy, log_on, led};
		repeat (20) @(negedge clk_in);
		chk({1'b0, sclk, scmd, doe, dout, rdy, log_on, led}, {1'b0, snap});
		ce = 1'b1;
		$display("clock enable freeze done");
		wait_cnt(bcnt, 6);
		$display("stream of 6 bytes done");
		press(90); exp_mnt = 0; state();
		wait_cnt(ccnt, 2);
		chk({2'h0, cidx}, {2'h0, lbsd_pkg::CMD_UNMOUNT});
		tally_and_finish();
	end
endmodule

`default_nettype wire

// [rtl/lbsd_buffer.sv]
`timescale 1ns/1ns
`default_nettype none

module lbsd_buffer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Filling side
	input wire lbsd_pkg::lbsd_stream_type wr_in,
	output logic wr_ready_out,
	// Draining side
	output lbsd_pkg::lbsd_stream_type rd_out,
	input wire logic rd_ready_in
);

	lbsd_pkg::lbsd_buf_state_type st;
	lbsd_pkg::lbsd_buf_state_type next_st;
	logic push;
	logic pop;

	// Handshakes; full and empty come straight from the count
	assign wr_ready_out = (st.count != 2'h2);
	assign rd_out = {(st.count != 2'h0), st.mem[st.rd_ptr]};
	assign push = wr_in.valid && wr_ready_out;
	assign pop = rd_out.valid && rd_ready_in;

	// Next state; push and pop in one cycle leave the count alone
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = wr_in.data;
			next_st.wr_ptr = ~st.wr_ptr;
		end
		if (pop) begin
			next_st.rd_ptr = ~st.rd_ptr;
		end
		if (push && !pop) begin
			next_st.count = st.count + 2'h1;
		end else if (pop && !push) begin
			next_st.count = st.count - 2'h1;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// Never more than two words held
	a_buf_count: assert property (@(posedge clk_in) disable iff (rst_in)
		st.count <= 2'h2)
		else $error("buffer count above two");

endmodule

`default_nettype wire

// [rtl/lbsd_control.sv]
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Button low between 100 ms and 5 s toggles logging on or off.
// - Button low over 5 s, then released, toggles the card mount state.
// - Button is debounced inside, so a bare mechanical contact works.
// - The logging status LED shows whether the card is mounted.
// - One-bit card bus: host drives clock and command, data line two-way.
// - Card clock never runs faster than 33 MHz.
// - Button idles high through a pull-up; a press is a low level.
module lbsd_control #(
	parameter int unsigned DEBOUNCE_CYC = lbsd_pkg::DEBOUNCE_CYC,
	parameter int unsigned PRESS_MIN_CYC = lbsd_pkg::PRESS_MIN_CYC,
	parameter int unsigned PRESS_LONG_CYC = lbsd_pkg::PRESS_LONG_CYC
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Push-button pin
	input wire logic log_push_button_in,
	// Log data stream
	input wire lbsd_pkg::lbsd_stream_type log_data_in,
	output logic log_ready_out,
	// Card bus
	output logic sd_clk_out,
	output logic sd_cmd_out,
	input wire logic sd_dat0_in,
	output logic sd_dat0_out,
	output logic sd_dat0_oe_out,
	// Status
	output logic logging_on_out,
	output logic logging_status_led_out
);

	lbsd_pkg::lbsd_state_type st;
	lbsd_pkg::lbsd_state_type next_st;
	lbsd_pkg::lbsd_stream_type buf_out;
	logic take;
	logic fall_tick;
	logic release_evt;

	// Two-entry buffer so a stalled card loses no word
	lbsd_buffer u_buffer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.wr_in(log_data_in),
		.wr_ready_out(log_ready_out),
		.rd_out(buf_out),
		.rd_ready_in(take)
	);

	// Outputs straight from state flops
	assign sd_clk_out = st.sd_clk;
	assign sd_cmd_out = st.cmd_line;
	assign sd_dat0_out = st.dat_line;
	assign sd_dat0_oe_out = st.dat_oe;
	assign logging_on_out = st.logging;
	assign logging_status_led_out = st.mounted;

	// Data leaves only on a falling card clock, so the card sees it settled
	assign fall_tick = (st.div_cnt == lbsd_pkg::SD_HALF_CYC - 4'h1) && st.sd_clk;
	assign take = fall_tick && (st.phase == lbsd_pkg::LBSD_IDLE) &&
		!st.cmd_pending && st.logging && st.mounted && buf_out.valid;
	// Release seen from present state only, so no loop through next state
	assign release_evt = !st.deb && st.btn_s2 &&
		(st.deb_cnt >= DEBOUNCE_CYC - 32'h1);

	// Next state of the whole block
	always_comb begin
		next_st = st;

		// Pin synchronisers; first stage feeds only the second
		next_st.btn_s1 = log_push_button_in;
		next_st.btn_s2 = st.btn_s1;
		next_st.dat_s1 = sd_dat0_in;
		next_st.dat_s2 = st.dat_s1;

		// Debounce: accept a new level only after it stays put long enough
		if (st.btn_s2 == st.deb) begin
			next_st.deb_cnt = 32'h0;
		end else if (st.deb_cnt >= DEBOUNCE_CYC - 32'h1) begin
			next_st.deb = st.btn_s2;
			next_st.deb_cnt = 32'h0;
		end else begin
			next_st.deb_cnt = st.deb_cnt + 32'h1;
		end

		// Length of the press, saturating just past the long limit
		if (!st.deb) begin
			if (st.press_cnt <= PRESS_LONG_CYC) begin
				next_st.press_cnt = st.press_cnt + 32'h1;
			end
		end else begin
			next_st.press_cnt = 32'h0;
		end

		// Classify on release; short presses fall through untouched
		if (!st.deb && next_st.deb) begin
			next_st.press_cnt = 32'h0;
			if (st.press_cnt > PRESS_LONG_CYC) begin
				next_st.mounted = !st.mounted;
				next_st.cmd_pending = 1'b1;
				next_st.cmd_code = st.mounted ? lbsd_pkg::CMD_UNMOUNT :
					lbsd_pkg::CMD_MOUNT;
			end else if (st.press_cnt >= PRESS_MIN_CYC) begin
				next_st.logging = !st.logging;
			end
		end

		// Card clock divider; half period fixed by the rate ceiling
		if (st.div_cnt == lbsd_pkg::SD_HALF_CYC - 4'h1) begin
			next_st.div_cnt = 4'h0;
			next_st.sd_clk = !st.sd_clk;
		end else begin
			next_st.div_cnt = st.div_cnt + 4'h1;
		end

		// Serial engine, stepped on each falling card clock
		if (fall_tick) begin
			case (st.phase)
				lbsd_pkg::LBSD_IDLE: begin
					if (st.cmd_pending) begin
						next_st.cmd_pending = release_evt && next_st.cmd_pending
							&& (next_st.mounted != st.mounted);
						next_st.cmd_line = 1'b0;
						next_st.shift = {1'b1, st.cmd_code, 1'b1, 2'b11};
						next_st.bits = lbsd_pkg::CMD_TAIL_BITS;
						next_st.phase = lbsd_pkg::LBSD_CMD;
					end else if (take) begin
						next_st.dat_oe = 1'b1;
						next_st.dat_line = 1'b0;
						next_st.shift = {buf_out.data, 1'b1, 1'b1};
						next_st.bits = lbsd_pkg::DAT_TAIL_BITS;
						next_st.phase = lbsd_pkg::LBSD_DAT;
					end
				end
				lbsd_pkg::LBSD_CMD: begin
					if (st.bits == 4'h0) begin
						next_st.cmd_line = lbsd_pkg::LINE_IDLE;
						next_st.phase = lbsd_pkg::LBSD_IDLE;
					end else begin
						next_st.cmd_line = st.shift[9];
						next_st.shift = {st.shift[8:0], 1'b1};
						next_st.bits = st.bits - 4'h1;
					end
				end
				lbsd_pkg::LBSD_DAT: begin
					if (st.bits == 4'h0) begin
						// Let go of the line so the card can signal busy
						next_st.dat_oe = 1'b0;
						next_st.dat_line = lbsd_pkg::LINE_IDLE;
						next_st.phase = lbsd_pkg::LBSD_BUSY;
					end else begin
						next_st.dat_line = st.shift[9];
						next_st.shift = {st.shift[8:0], 1'b1};
						next_st.bits = st.bits - 4'h1;
					end
				end
				lbsd_pkg::LBSD_BUSY: begin
					// Card holds the data line low while it is busy
					if (st.dat_s2) begin
						next_st.phase = lbsd_pkg::LBSD_IDLE;
					end
				end
				default: begin
					next_st.phase = lbsd_pkg::LBSD_IDLE;
				end
			endcase
		end
	end

	// State register; idle button level covers the pull-up before sampling
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
			st.btn_s1 <= lbsd_pkg::BTN_IDLE;
			st.btn_s2 <= lbsd_pkg::BTN_IDLE;
			st.deb <= lbsd_pkg::BTN_IDLE;
			st.dat_s1 <= lbsd_pkg::LINE_IDLE;
			st.dat_s2 <= lbsd_pkg::LINE_IDLE;
			st.cmd_line <= lbsd_pkg::LINE_IDLE;
			st.dat_line <= lbsd_pkg::LINE_IDLE;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// Checks on the push-button path
	a_short_no_change: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && release_evt && st.press_cnt < PRESS_MIN_CYC) |->
		(next_st.logging == st.logging && next_st.mounted == st.mounted))
		else $error("short press changed state");

	a_log_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && release_evt && st.press_cnt >= PRESS_MIN_CYC &&
		st.press_cnt <= PRESS_LONG_CYC) |=> (st.logging != $past(st.logging)) ||
		!$past(ce_in))
		else $error("logging did not toggle");

	a_mount_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && release_evt && st.press_cnt > PRESS_LONG_CYC) |->
		(next_st.mounted != st.mounted && next_st.logging == st.logging))
		else $error("mount did not toggle");

	a_debounce_level: assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(st.deb) |-> (st.deb == $past(st.btn_s2)))
		else $error("debounced level not from pin");

	a_led_mount: assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(logging_status_led_out) |->
		$past(ce_in && release_evt && st.press_cnt > PRESS_LONG_CYC))
		else $error("led changed without long press");

	a_idle_no_count: assert property (@(posedge clk_in) disable iff (rst_in)
		st.deb |-> (st.press_cnt == 32'h0))
		else $error("press counted while idle high");

	// Checks on the card bus
	a_clk_high_min: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(sd_clk_out) |-> sd_clk_out[*2])
		else $error("card clock high too short");

	a_clk_low_min: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(sd_clk_out) |-> !sd_clk_out[*2])
		else $error("card clock low too short");

	a_dat_own_frame: assert property (@(posedge clk_in) disable iff (rst_in)
		sd_dat0_oe_out |-> (st.phase == lbsd_pkg::LBSD_DAT))
		else $error("data line driven outside frame");

	a_cmd_idle_high: assert property (@(posedge clk_in) disable iff (rst_in)
		(st.phase == lbsd_pkg::LBSD_IDLE) |-> sd_cmd_out)
		else $error("command line low while idle");

endmodule

`default_nettype wire

// [rtl/lbsd_pkg.sv]
package lbsd_pkg;

	// Timing base
	localparam int unsigned CLK_HZ = 32'd100_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 32'd1000;

	// Button timing, in milliseconds as specified
	localparam int unsigned PRESS_MIN_MS = 32'd100;
	localparam int unsigned PRESS_LONG_MS = 32'd5000;
	localparam int unsigned DEBOUNCE_MS = 32'd10;
	localparam int unsigned PRESS_MIN_CYC = PRESS_MIN_MS * CYC_PER_MS;
	localparam int unsigned PRESS_LONG_CYC = PRESS_LONG_MS * CYC_PER_MS;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;

	// Card clock ceiling; half period rounds up so the rate never exceeds it
	localparam int unsigned SD_MAX_HZ = 32'd33_000_000;
	localparam logic [3:0] SD_HALF_CYC =
		4'((CLK_HZ + 2 * SD_MAX_HZ - 1) / (2 * SD_MAX_HZ));

	// Command indices sent on the command line at mount and unmount
	localparam logic [5:0] CMD_MOUNT = 6'h07;
	localparam logic [5:0] CMD_UNMOUNT = 6'h0f;

	// Bit counts of the serial frames after the start bit
	localparam logic [3:0] CMD_TAIL_BITS = 4'h8;
	localparam logic [3:0] DAT_TAIL_BITS = 4'h9;

	// Reset values
	localparam logic BTN_IDLE = 1'b1;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [1:0] {
		LBSD_IDLE = 2'b00,
		LBSD_CMD = 2'b01,
		LBSD_DAT = 2'b10,
		LBSD_BUSY = 2'b11
	} lbsd_phase_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} lbsd_stream_type;

	typedef struct packed {
		logic [1:0][7:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} lbsd_buf_state_type;

	typedef struct packed {
		logic btn_s1;
		logic btn_s2;
		logic deb;
		logic [31:0] deb_cnt;
		logic [31:0] press_cnt;
		logic logging;
		logic mounted;
		logic [3:0] div_cnt;
		logic sd_clk;
		logic dat_s1;
		logic dat_s2;
		lbsd_phase_type phase;
		logic [9:0] shift;
		logic [3:0] bits;
		logic cmd_pending;
		logic [5:0] cmd_code;
		logic cmd_line;
		logic dat_line;
		logic dat_oe;
	} lbsd_state_type;

endpackage
